// [core/ppc_defines.svh]
/*
 Register offsets, field positions and reset values for the port pin
 control block. Assumes inclusion by the top module; core/ppc_pkg.sv does not include it.
*/
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

`define PPC_ADDR_W          4
`define PPC_OFF_PINS        4'h0
`define PPC_OFF_LATCH       4'h1
`define PPC_OFF_DIR         4'h2
`define PPC_OFF_SEG         4'h3
`define PPC_OFF_ANSEL       4'h4
`define PPC_OFF_OD_FIRST    4'h5
`define PPC_OFF_OD_SECOND   4'h6
`define PPC_OFF_OD_THIRD    4'h7
`define PPC_OFF_STATUS      4'h8

`define PPC_DIR_RESET       8'hff
`define PPC_LATCH_RESET     8'h00
`define PPC_SEG_RESET       8'h00
`define PPC_ANSEL_RESET     8'hff
`define PPC_OD_RESET        8'h00
`define PPC_ZERO            8'h00
`define PPC_PIN_ANALOG_MASK 8'h03
`define PPC_SEG_PIN_MASK    8'hfe
`define PPC_OSC_PIN_MASK    8'h03
`define PPC_OD_FIRST_MASK   8'he1

`define PPC_OSC_DIGITAL     2'h2
`define PPC_OD_SSP_BIT      7
`define PPC_OD_CCP2_BIT     6
`define PPC_OD_CCP1_BIT     5
`define PPC_OD_UART_BIT     0
`define PPC_CCP_PIN_DEFAULT 1
`define PPC_CCP_PIN_ALT     3
`define PPC_SER_CLK_PIN     3
`define PPC_SER_DOUT_PIN    5
`define PPC_UART_TX_PIN     6
`define PPC_CCP1_PIN        2
`define PPC_PWMD_PIN        7
`define PPC_MCLR_BIT        5

`endif

// [core/ppc_pkg.sv]
/*
 Types for the port pin control block.
 Assumes ppc_defines.svh is in the include path.
*/
package ppc_pkg;
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] seg;
        logic [7:0] ansel;
        logic [7:0] od_first;
        logic [7:0] od_third;
        logic [7:0] sync_pins;
        logic [7:0] rdata;
        logic [7:0] g_latch;
        logic [7:0] g_dir;
        logic [7:0] pin_out;
        logic [7:0] pin_oen;
    } ppc_state_type;
endpackage

// [core/ppc_port.sv]
/*
 Third-port pin control: latch, direction, open-drain, segment and
 analog selection with peripheral overrides. Assumes a simple register
 port driven synchronously to i_clk and pins resolved by the testbench.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
// Overview of operation
// - Eight bidirectional pins, each with direction bit and output latch.
// - Pins two to seven have no analog select; only pins zero, one.
// - Pins are sampled into a register as Schmitt-buffered inputs.
// - Active serial or capture outputs drive open-drain when enabled.
// - Second capture unit uses pin one unless select input is low.
// - Active peripherals force pin direction regardless of direction bit.
// - Any reset returns all pins to inputs.
// - Direction reads return stored bits despite overrides.
// - Pins one to seven are shared with segment drivers.
// - Pins zero, one are digital only when oscillator field is 10.
// - Oscillator pins are digital only with their segment disabled.
// - Active peripheral output value replaces the latch value.
// - Segment enable disables the pin driver and analog select, not input sampling.
// - Analog select is reset default and leaves output driver on.
// - PWM output D may tri-state when configured.
// - Reset-shared bit exists only while master clear is disabled.
// - Unimplemented bits read as zero.
// - Input-only functions see pins regardless of direction.
`timescale 1ns/1ps
`include "ppc_defines.svh"

module ppc_port
    import ppc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  wire logic [`PPC_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic [7:0]                  o_rdata,
    input  wire logic [1:0]             i_oscillator_pin_config,
    input  wire logic                   i_second_capture_pin_select,
    input  wire logic                   i_master_clear_enable,
    input  wire logic                   i_ccp1_en,
    input  wire logic                   i_ccp1_out,
    input  wire logic                   i_ccp2_en,
    input  wire logic                   i_ccp2_out,
    input  wire logic                   i_ser_en,
    input  wire logic                   i_ser_clk_out,
    input  wire logic                   i_ser_dout,
    input  wire logic                   i_uart_en,
    input  wire logic                   i_uart_tx,
    input  wire logic                   i_pwm_d_en,
    input  wire logic                   i_pwm_d_out,
    input  wire logic                   i_pwm_d_tristate,
    input  wire logic [7:0]             i_pin,
    output logic [7:0]                  o_pin,
    output logic [7:0]                  o_pin_oen,
    output logic [7:0]                  o_pin_in,
    output logic [7:0]                  o_seg_en,
    output logic [1:0]                  o_analog_en,
    output logic                        o_osc_pins_osc
);

    initial begin
        if (WIDTH != 8) begin
            $error("ppc_port supports only an 8-bit port");
        end
    end

    ppc_state_type st;
    ppc_state_type next_st;

    logic [7:0] per_en;
    logic [7:0] per_val;
    logic [7:0] per_od;
    logic [7:0] digital_ok;
    logic [7:0] drive;
    logic [7:0] value;

    function automatic logic hit(input logic [`PPC_ADDR_W-1:0] a,
                                 input logic [`PPC_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Peripheral ownership map; overrides the direction bit
    always_comb begin
        per_en  = `PPC_ZERO;
        per_val = `PPC_ZERO;
        per_od  = `PPC_ZERO;
        if (i_ccp1_en) begin
            per_en[`PPC_CCP1_PIN]  = 1'b1;
            per_val[`PPC_CCP1_PIN] = i_ccp1_out;
            per_od[`PPC_CCP1_PIN]  = st.od_first[`PPC_OD_CCP1_BIT];
        end
        // Pin choice follows the configuration bit
        if (i_ccp2_en && i_second_capture_pin_select) begin
            per_en[`PPC_CCP_PIN_DEFAULT]  = 1'b1;
            per_val[`PPC_CCP_PIN_DEFAULT] = i_ccp2_out;
            per_od[`PPC_CCP_PIN_DEFAULT]  = st.od_first[`PPC_OD_CCP2_BIT];
        end
        if (i_ser_en) begin
            per_en[`PPC_SER_CLK_PIN]   = 1'b1;
            per_val[`PPC_SER_CLK_PIN]  = i_ser_clk_out;
            per_od[`PPC_SER_CLK_PIN]   = st.od_first[`PPC_OD_SSP_BIT];
            per_en[`PPC_SER_DOUT_PIN]  = 1'b1;
            per_val[`PPC_SER_DOUT_PIN] = i_ser_dout;
            per_od[`PPC_SER_DOUT_PIN]  = st.od_first[`PPC_OD_SSP_BIT];
        end
        if (i_ccp2_en && !i_second_capture_pin_select) begin
            per_en[`PPC_CCP_PIN_ALT]  = 1'b1;
            per_val[`PPC_CCP_PIN_ALT] = i_ccp2_out;
            per_od[`PPC_CCP_PIN_ALT]  = st.od_first[`PPC_OD_CCP2_BIT];
        end
        if (i_uart_en) begin
            per_en[`PPC_UART_TX_PIN]  = 1'b1;
            per_val[`PPC_UART_TX_PIN] = i_uart_tx;
            per_od[`PPC_UART_TX_PIN]  = st.od_third[`PPC_OD_UART_BIT];
        end
        if (i_pwm_d_en) begin
            per_en[`PPC_PWMD_PIN]  = 1'b1;
            per_val[`PPC_PWMD_PIN] = i_pwm_d_out;
        end
    end

    // Oscillator pins need digital mode and no segment
    always_comb begin
        digital_ok = ~(st.seg & `PPC_SEG_PIN_MASK);
        if (i_oscillator_pin_config != `PPC_OSC_DIGITAL) begin
            digital_ok = digital_ok & ~`PPC_OSC_PIN_MASK;
        end
    end

    always_comb begin
        next_st = st;
        for (int i = 0; i < 8; i++) begin
            // Analog select never gates the driver
            drive[i] = digital_ok[i] & (per_en[i] | ~st.dir[i]);
            value[i] = per_en[i] ? per_val[i] : st.latch[i];
            if (per_en[i] && per_od[i] && per_val[i]) begin
                drive[i] = 1'b0;
            end
        end
        if (i_pwm_d_en && i_pwm_d_tristate) begin
            drive[`PPC_PWMD_PIN] = 1'b0;
        end
        next_st.sync_pins = i_pin;
        next_st.pin_out   = value;
        next_st.pin_oen   = ~drive;
        next_st.rdata     = `PPC_ZERO;
        if (i_wr) begin
            if (hit(i_addr, `PPC_OFF_PINS) || hit(i_addr, `PPC_OFF_LATCH)) begin
                next_st.latch = i_wdata;
            end
            if (hit(i_addr, `PPC_OFF_DIR)) begin
                next_st.dir = i_wdata;
            end
            if (hit(i_addr, `PPC_OFF_SEG)) begin
                next_st.seg = i_wdata & `PPC_SEG_PIN_MASK;
            end
            if (hit(i_addr, `PPC_OFF_ANSEL)) begin
                next_st.ansel = i_wdata & `PPC_PIN_ANALOG_MASK;
            end
            if (hit(i_addr, `PPC_OFF_OD_FIRST)) begin
                next_st.od_first = i_wdata & `PPC_OD_FIRST_MASK;
            end
            if (hit(i_addr, `PPC_OFF_OD_THIRD)) begin
                next_st.od_third = i_wdata;
            end
            if (hit(i_addr, `PPC_OFF_PINS) && !i_master_clear_enable) begin
                next_st.g_latch = i_wdata;
            end
            if (hit(i_addr, `PPC_OFF_OD_SECOND)) begin
                next_st.g_dir = i_wdata;
            end
        end
        if (i_rd) begin
            case (i_addr)
                `PPC_OFF_PINS:      next_st.rdata = st.sync_pins;
                `PPC_OFF_LATCH:     next_st.rdata = st.latch;
                `PPC_OFF_DIR:       next_st.rdata = st.dir;
                `PPC_OFF_SEG:       next_st.rdata = st.seg;
                `PPC_OFF_ANSEL:     next_st.rdata = st.ansel;
                `PPC_OFF_OD_FIRST:  next_st.rdata = st.od_first;
                `PPC_OFF_OD_SECOND: next_st.rdata = st.g_dir;
                `PPC_OFF_OD_THIRD:  next_st.rdata = st.od_third;
                `PPC_OFF_STATUS: begin
                    // Reset-shared bit hidden while master clear on
                    next_st.rdata = `PPC_ZERO;
                    if (!i_master_clear_enable) begin
                        next_st.rdata[`PPC_MCLR_BIT] = st.g_latch[`PPC_MCLR_BIT];
                    end
                end
                default:            next_st.rdata = `PPC_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st          <= '0;
            st.dir      <= `PPC_DIR_RESET;
            st.latch    <= `PPC_LATCH_RESET;
            st.seg      <= `PPC_SEG_RESET;
            st.ansel    <= `PPC_ANSEL_RESET & `PPC_PIN_ANALOG_MASK;
            st.od_first <= `PPC_OD_RESET;
            st.od_third <= `PPC_OD_RESET;
            st.pin_oen  <= `PPC_DIR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata        = st.rdata;
    assign o_pin          = st.pin_out;
    assign o_pin_oen      = st.pin_oen;
    assign o_pin_in       = st.sync_pins;
    assign o_seg_en       = st.seg;
    assign o_analog_en    = st.ansel[1:0] & digital_ok[1:0];
    assign o_osc_pins_osc = (i_oscillator_pin_config != `PPC_OSC_DIGITAL);

    // Hidden bits are always read as zero
    property p_seg_bit0_zero;
        @(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `PPC_OFF_SEG |=> o_rdata[0] == 1'b0;
    endproperty
    a_seg_bit0_zero: assert property (p_seg_bit0_zero)
        else $error("segment bit 0 read nonzero");

    property p_dir_read;
        @(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `PPC_OFF_DIR |=> o_rdata == $past(st.dir);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read mismatch");

    property p_reset_inputs;
        @(posedge i_clk) !i_resetn |=> o_pin_oen == `PPC_DIR_RESET;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins not inputs after reset");

    property p_seg_kills;
        @(posedge i_clk) disable iff (!i_resetn)
        st.seg[4] |=> o_pin_oen[4];
    endproperty
    a_seg_kills: assert property (p_seg_kills)
        else $error("segment pin still driven");

    property p_latch_write;
        @(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == `PPC_OFF_LATCH ##1 !i_wr
            |-> st.latch == $past(i_wdata);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch not updated");

    property p_uart_value;
        @(posedge i_clk) disable iff (!i_resetn)
        i_uart_en |=> o_pin[6] == $past(i_uart_tx);
    endproperty
    a_uart_value: assert property (p_uart_value)
        else $error("peripheral value not driven");

    property p_osc_pins;
        @(posedge i_clk) disable iff (!i_resetn)
        i_oscillator_pin_config != `PPC_OSC_DIGITAL |=> o_pin_oen[0];
    endproperty
    a_osc_pins: assert property (p_osc_pins)
        else $error("oscillator pin driven");

    property p_pwm_tri;
        @(posedge i_clk) disable iff (!i_resetn)
        i_pwm_d_en && i_pwm_d_tristate |=> o_pin_oen[7];
    endproperty
    a_pwm_tri: assert property (p_pwm_tri)
        else $error("pwm d not tri-stated");

    // Open-drain control bits four to one do not exist
    property p_od_first_read;
        @(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `PPC_OFF_OD_FIRST
            |=> (o_rdata & ~`PPC_OD_FIRST_MASK) == `PPC_ZERO;
    endproperty
    a_od_first_read: assert property (p_od_first_read)
        else $error("open-drain hidden bits read nonzero");

    property p_status_hidden;
        @(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `PPC_OFF_STATUS && i_master_clear_enable
            |=> o_rdata == `PPC_ZERO;
    endproperty
    a_status_hidden: assert property (p_status_hidden)
        else $error("reset-shared bit visible with master clear");

    // Idle read data is zero so a bus mux can simply OR slaves
    property p_read_idle;
        @(posedge i_clk) disable iff (!i_resetn)
        !i_rd |=> o_rdata == `PPC_ZERO;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data not zero when idle");

    property p_pin_sample;
        @(posedge i_clk) disable iff (!i_resetn)
        1'b1 |=> o_pin_in == $past(i_pin);
    endproperty
    a_pin_sample: assert property (p_pin_sample)
        else $error("pin levels not sampled");

    property p_ccp2_default;
        @(posedge i_clk) disable iff (!i_resetn)
        i_ccp2_en && i_second_capture_pin_select
            |=> o_pin[`PPC_CCP_PIN_DEFAULT] == $past(i_ccp2_out);
    endproperty
    a_ccp2_default: assert property (p_ccp2_default)
        else $error("capture unit two not on default pin");

    // Alternate pin wins over the serial clock on a shared pin
    property p_ccp2_alt;
        @(posedge i_clk) disable iff (!i_resetn)
        i_ccp2_en && !i_second_capture_pin_select
            |=> o_pin[`PPC_CCP_PIN_ALT] == $past(i_ccp2_out);
    endproperty
    a_ccp2_alt: assert property (p_ccp2_alt)
        else $error("capture unit two not on alternate pin");

    property p_ccp1_value;
        @(posedge i_clk) disable iff (!i_resetn)
        i_ccp1_en |=> o_pin[`PPC_CCP1_PIN] == $past(i_ccp1_out);
    endproperty
    a_ccp1_value: assert property (p_ccp1_value)
        else $error("capture unit one value not driven");

    property p_pwm_value;
        @(posedge i_clk) disable iff (!i_resetn)
        i_pwm_d_en |=> o_pin[`PPC_PWMD_PIN] == $past(i_pwm_d_out);
    endproperty
    a_pwm_value: assert property (p_pwm_value)
        else $error("pwm d value not driven");

    property p_ser_value;
        @(posedge i_clk) disable iff (!i_resetn)
        i_ser_en |=> o_pin[`PPC_SER_DOUT_PIN] == $past(i_ser_dout);
    endproperty
    a_ser_value: assert property (p_ser_value)
        else $error("serial data not driven");

    property p_uart_od;
        @(posedge i_clk) disable iff (!i_resetn)
        i_uart_en && st.od_third[`PPC_OD_UART_BIT] && i_uart_tx
            |=> o_pin_oen[`PPC_UART_TX_PIN];
    endproperty
    a_uart_od: assert property (p_uart_od)
        else $error("open-drain transmit high still driven");

    property p_ser_od;
        @(posedge i_clk) disable iff (!i_resetn)
        i_ser_en && st.od_first[`PPC_OD_SSP_BIT] && i_ser_dout
            |=> o_pin_oen[`PPC_SER_DOUT_PIN];
    endproperty
    a_ser_od: assert property (p_ser_od)
        else $error("open-drain serial high still driven");

    property p_latch_pass;
        @(posedge i_clk) disable iff (!i_resetn)
        per_en == `PPC_ZERO |=> o_pin == $past(st.latch);
    endproperty
    a_latch_pass: assert property (p_latch_pass)
        else $error("latch not on pins");

    property p_dir_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        per_en == `PPC_ZERO && st.dir == `PPC_DIR_RESET
            |=> o_pin_oen == `PPC_DIR_RESET;
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("input pin driven without owner");

    property p_ansel_mask;
        @(posedge i_clk) disable iff (!i_resetn)
        (st.ansel & ~`PPC_PIN_ANALOG_MASK) == `PPC_ZERO;
    endproperty
    a_ansel_mask: assert property (p_ansel_mask)
        else $error("analog select on digital-only pin");

    c_ccp2_alt: cover property (@(posedge i_clk)
        i_ccp2_en && !i_second_capture_pin_select);
    c_od_rel: cover property (@(posedge i_clk)
        (per_en & per_od) != `PPC_ZERO);
    c_uart: cover property (@(posedge i_clk) i_uart_en ##1 !o_pin_oen[6]);
    c_seg:  cover property (@(posedge i_clk) st.seg != `PPC_ZERO);
    c_dir:  cover property (@(posedge i_clk) i_wr && i_addr == `PPC_OFF_DIR);

endmodule

// [dv/ppc_pin_model.sv]
/*
 Pin-side model: resolves each pad from the port drive and an external
 source. Assumes active-low output enables and a weak pull-up per pad.
*/
`timescale 1ns/1ps

module ppc_pin_model (
    input  wire logic [7:0] i_pin_out,
    input  wire logic [7:0] i_pin_oen,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output logic [7:0]      o_pin_level
);
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (!i_pin_oen[k]) begin
                o_pin_level[k] = i_pin_out[k];
            end else if (i_ext_en[k]) begin
                o_pin_level[k] = i_ext_val[k];
            end else begin
                // Released pad floats up, as open-drain needs
                o_pin_level[k] = 1'b1;
            end
        end
    end
endmodule

// [dv/ppc_port_tb.sv]
/*
 Self-checking bench for the port pin control block.
 Assumes the pin model in dv/ and a 4 ns clock.
*/
`timescale 1ns/1ps

module ppc_port_tb;
    logic       clk, resetn, bus_wr, bus_rd, sel2, mce, c1e, c1o, c2e, c2o;
    logic       se, sck, sdo, ue, utx, pe, po, pt, oscp;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pin, pout, poen, pin_in, seg, ext_en, ext_val;
    logic [7:0] rv;
    logic [1:0] osc, ana;
    int         err_count, num_checks, cycles;

    ppc_port i_ppc_port (.i_clk(clk), .i_resetn(resetn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
        .i_oscillator_pin_config(osc), .i_second_capture_pin_select(sel2),
        .i_master_clear_enable(mce), .i_ccp1_en(c1e), .i_ccp1_out(c1o),
        .i_ccp2_en(c2e), .i_ccp2_out(c2o), .i_ser_en(se),
        .i_ser_clk_out(sck), .i_ser_dout(sdo), .i_uart_en(ue),
        .i_uart_tx(utx), .i_pwm_d_en(pe), .i_pwm_d_out(po),
        .i_pwm_d_tristate(pt), .i_pin(pin), .o_pin(pout), .o_pin_oen(poen),
        .o_pin_in(pin_in), .o_seg_en(seg), .o_analog_en(ana),
        .o_osc_pins_osc(oscp));
    ppc_pin_model i_ppc_pin_model (.i_pin_out(pout), .i_pin_oen(poen),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin_level(pin));

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end

    task automatic conclude;
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk); bus_wr <= 1; addr <= a; wdata <= d;
        @(posedge clk); bus_wr <= 0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk); bus_rd <= 1; addr <= a;
        @(posedge clk); bus_rd <= 0;
        #1 d = rdata;
    endtask

    // Pins lag the register write by one registered stage
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        logic [7:0] exp [10] = '{0, 8'h00, 8'hff, 0, 8'h03, 0, 0, 0, 0, 0};
        for (int a = 1; a < 10; a++) begin
            rd(a[3:0], rv);
            chk(rv, exp[a]);
        end
        chk(poen, 8'hff);
        chk({7'h0, oscp}, 8'h01);
    endtask

    task automatic t_digital;
        wr(4'h2, 8'h00);
        settle();
        chk(poen, 8'h03);
        @(posedge clk); osc <= 2'b10;
        settle();
        chk(poen, 8'h00);
        wr(4'h0, 8'ha5);
        settle();
        chk(pout, 8'ha5);
        rd(4'h0, rv);
        chk(rv, 8'ha5);
        wr(4'h3, 8'h02);
        settle();
        chk(poen, 8'h02);
        wr(4'h3, 8'hff);
        rd(4'h3, rv);
        chk(rv, 8'hfe);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'hff);
        rd(4'h4, rv);
        chk(rv, 8'h03);
        wr(4'h1, 8'h5a);
        rd(4'h1, rv);
        chk(rv, 8'h5a);
    endtask

    task automatic t_periph;
        wr(4'h2, 8'hff);
        @(posedge clk); ue <= 1; utx <= 0;
        settle();
        chk(poen, 8'hbf);
        chk({7'h0, pout[6]}, 8'h00);
        rd(4'h2, rv);
        chk(rv, 8'hff);
        wr(4'h7, 8'h01);
        @(posedge clk); utx <= 1;
        settle();
        chk(poen, 8'hff);
        wr(4'h3, 8'h40);
        @(posedge clk); utx <= 0;
        settle();
        chk(poen, 8'hff);
        chk(seg, 8'h40);
        wr(4'h3, 8'h00);
        @(posedge clk); ue <= 0; c2e <= 1; c2o <= 1; sel2 <= 1;
        settle();
        chk(poen, 8'hfd);
        chk({7'h0, pout[1]}, 8'h01);
        @(posedge clk); sel2 <= 0;
        settle();
        chk(poen, 8'hf7);
        @(posedge clk); c2e <= 0; pe <= 1; po <= 0;
        settle();
        chk(poen, 8'h7f);
        @(posedge clk); pt <= 1;
        settle();
        chk(poen, 8'hff);
        @(posedge clk); pe <= 0; pt <= 0;
    endtask

    task automatic t_inputs;
        @(posedge clk); ext_en <= 8'hff; ext_val <= 8'h3c;
        settle();
        chk(pin_in, 8'h3c);
        rd(4'h0, rv);
        chk(rv, 8'h3c);
        @(posedge clk); mce <= 0;
        wr(4'h0, 8'hff);
        rd(4'h8, rv);
        chk(rv, 8'h20);
        @(posedge clk); mce <= 1;
        rd(4'h8, rv);
        chk(rv, 8'h00);
    endtask

    task automatic t_serial;
        wr(4'h5, 8'hff);
        rd(4'h5, rv);
        chk(rv, 8'he1);
        @(posedge clk); c1e <= 1; c1o <= 1; se <= 1; sck <= 0; sdo <= 1;
        settle();
        chk(poen, 8'hf7);
        chk(pout, 8'hf7);
        @(posedge clk); c1o <= 0; sdo <= 0;
        settle();
        chk(poen, 8'hd3);
        @(posedge clk); c1e <= 0; se <= 0;
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h10);
        settle();
        chk(poen, 8'h10);
        wr(4'h3, 8'h00);
    endtask

    task automatic t_rerun;
        wr(4'h2, 8'h00);
        @(posedge clk); resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        #1 chk(poen, 8'hff);
    endtask

    initial begin
        {bus_wr, bus_rd, sel2, c1e, c1o, c2e, c2o, se, sck, sdo} = '0;
        {ue, utx, pe, po, pt, resetn} = '0;
        mce = 1;
        addr = '0;
        wdata = '0;
        osc = 2'b00;
        ext_en = '0;
        ext_val = '0;
        repeat (12) @(posedge clk);
        resetn <= 1;
        t_reset();
        t_digital();
        t_periph();
        t_inputs();
        t_serial();
        t_rerun();
        conclude();
    end
endmodule
